// File: hw/sbe_pkg.sv
// Package for the secondary-bus uncorrectable error flag and gate bank.
// Assumes a 4 KB extended configuration space of 32-bit words, reached by 12-bit byte offset.
package sbe_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int unsigned SBE_CFG_AW = 12;
  localparam int unsigned SBE_REG_W = 32;
  localparam logic [SBE_CFG_AW-1:0] SBE_FLAGS_OFS = 12'h12C;
  localparam logic [SBE_CFG_AW-1:0] SBE_MASKS_OFS = 12'h130;

  // ----------------------------------------------------------------
  // Reset values and implemented bits
  // ----------------------------------------------------------------
  localparam logic [SBE_REG_W-1:0] SBE_FLAGS_RESET = 32'h0000_0000;
  localparam logic [SBE_REG_W-1:0] SBE_MASKS_RESET = 32'h0000_17A8;
  localparam logic [SBE_REG_W-1:0] SBE_FLAGS_IMPL = 32'h0000_1E8C;
  localparam logic [SBE_REG_W-1:0] SBE_MASKS_IMPL = 32'h0000_3FEE;

  // ----------------------------------------------------------------
  // Field positions shared by flags and gates
  // ----------------------------------------------------------------
  localparam int unsigned SBE_SYSERR_BIT = 12;
  localparam int unsigned SBE_PARSIG_BIT = 11;
  localparam int unsigned SBE_DISCARD_BIT = 10;
  localparam int unsigned SBE_ADDRPAR_BIT = 9;
  localparam int unsigned SBE_DATAPAR_BIT = 7;
  localparam int unsigned SBE_MABORT_BIT = 3;
  localparam int unsigned SBE_TABORT_BIT = 2;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned SBE_CFG_ACK_LAT = 1;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic system_error_seen;
    logic parity_signal_seen;
    logic discard_timer_expired;
    logic address_parity;
    logic write_data_parity;
    logic read_cpl_parity_signal;
    logic master_abort;
    logic target_abort;
  } sbe_sec_evt_s;

  typedef struct packed {
    logic valid;
    logic write;
    logic [SBE_CFG_AW-1:0] addr;
    logic [3:0] be;
    logic [SBE_REG_W-1:0] wdata;
  } sbe_cfg_req_s;

  typedef struct packed {
    logic ack;
    logic [SBE_REG_W-1:0] rdata;
  } sbe_cfg_rsp_s;

  typedef struct packed {
    logic [SBE_REG_W-1:0] flags;
    logic [SBE_REG_W-1:0] masks;
    sbe_cfg_rsp_s rsp;
    logic [SBE_REG_W-1:0] report;
  } sbe_state_s;

endpackage : sbe_pkg

// File: hw/sbe_event_map.sv
// Maps secondary-bus error events onto their flag positions.
// Assumes events are one-cycle pulses synchronous to the core clock.
`timescale 1ns/1ps
module sbe_event_map
  import sbe_pkg::*;
(
  // Secondary bus events
  input  wire sbe_pkg::sbe_sec_evt_s evt_i,
  // Events by flag position
  output logic [sbe_pkg::SBE_REG_W-1:0] raw_o
);

  always_comb
  begin
    raw_o = '0;
    raw_o[SBE_SYSERR_BIT] = evt_i.system_error_seen;
    raw_o[SBE_PARSIG_BIT] = evt_i.parity_signal_seen;
    raw_o[SBE_DISCARD_BIT] = evt_i.discard_timer_expired;
    raw_o[SBE_ADDRPAR_BIT] = evt_i.address_parity;
    raw_o[SBE_DATAPAR_BIT] = evt_i.write_data_parity | evt_i.read_cpl_parity_signal;
    raw_o[SBE_MABORT_BIT] = evt_i.master_abort;
    raw_o[SBE_TABORT_BIT] = evt_i.target_abort;
  end

endmodule : sbe_event_map

// File: hw/sbe_error_bank.sv
// Secondary-bus uncorrectable error flags (write-one-to-clear) and gates.
// Assumes configuration requests arrive as single-cycle strobes.
//
// Operation
// - Flags sticky; software clears by writing one
// - Bit 12 set on secondary system error
// - Bit 11 set on secondary parity signal
// - Bit 10 set on discard timer expiry
// - Bit 9 set on upstream address parity
// - Bit 7 set on data parity errors
// - Bit 3 set on initiated master abort
// - Bit 2 set on initiated target abort
// - Reserved bits read zero, ignore writes
// - Gated error sets nothing and reports nothing
// - Gate bits at flag positions are read/write
// - Extended-bus gate bits are plain storage
// - Defaults on fundamental reset, active low, and also on sys_rst_i
`timescale 1ns/1ps
module sbe_error_bank
  import sbe_pkg::*;
#(
  parameter int unsigned REG_W = 32
)
(
  // Clock and resets
  input  wire logic sys_clk_i,
  input  wire logic sys_rst_i,
  input  wire logic pcie_reset_n_i,
  input  wire logic global_reset_pin_n_i,
  // Secondary bus events
  input  wire sbe_pkg::sbe_sec_evt_s sec_evt_i,
  // Configuration access
  input  wire sbe_pkg::sbe_cfg_req_s cfg_req_i,
  output sbe_pkg::sbe_cfg_rsp_s cfg_rsp_o,
  // Status towards reporting logic
  output logic fundamental_reset_n_o,
  output logic [sbe_pkg::SBE_REG_W-1:0] flags_o,
  output logic [sbe_pkg::SBE_REG_W-1:0] masks_o,
  output logic [sbe_pkg::SBE_REG_W-1:0] report_o
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (REG_W != SBE_REG_W)
  begin : g_bad_width
    $error("sbe_error_bank: REG_W must equal the configuration word width");
  end

  // ----------------------------------------------------------------
  // Reset
  // ----------------------------------------------------------------
  logic fundamental_reset_n;
  logic bank_rst;

  assign fundamental_reset_n = pcie_reset_n_i & global_reset_pin_n_i;
  assign bank_rst = sys_rst_i | ~fundamental_reset_n;
  assign fundamental_reset_n_o = fundamental_reset_n;

  // ----------------------------------------------------------------
  // Event mapping and gating
  // ----------------------------------------------------------------
  logic [SBE_REG_W-1:0] raw_v;
  logic [SBE_REG_W-1:0] evt_v;

  sbe_event_map u_event_map (
    .evt_i (sec_evt_i),
    .raw_o (raw_v)
  );

  sbe_state_s s_q;
  sbe_state_s s_d;

  // Extended-bus gate bits have no event behind them, so they gate nothing
  assign evt_v = raw_v & ~s_q.masks & SBE_FLAGS_IMPL;

  // ----------------------------------------------------------------
  // Configuration decode
  // ----------------------------------------------------------------
  logic [SBE_REG_W-1:0] be_mask;
  logic hit_flags;
  logic hit_masks;
  logic wr_flags;
  logic wr_masks;
  logic [SBE_REG_W-1:0] clr_v;
  logic [SBE_REG_W-1:0] mask_wr_sel;

  for (genvar b = 0; b < 4; b++)
  begin : g_be
    assign be_mask[8*b +: 8] = {8{cfg_req_i.be[b]}};
  end

  assign hit_flags = cfg_req_i.addr == SBE_FLAGS_OFS;
  assign hit_masks = cfg_req_i.addr == SBE_MASKS_OFS;
  assign wr_flags = cfg_req_i.valid & cfg_req_i.write & hit_flags;
  assign wr_masks = cfg_req_i.valid & cfg_req_i.write & hit_masks;
  assign clr_v = wr_flags ? (cfg_req_i.wdata & be_mask & SBE_FLAGS_IMPL) : '0;
  assign mask_wr_sel = wr_masks ? (be_mask & SBE_MASKS_IMPL) : '0;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    s_d = s_q;
    // New events land after the clear, so a clash leaves the flag set
    s_d.flags = (s_q.flags & ~clr_v) | evt_v;
    s_d.masks = (s_q.masks & ~mask_wr_sel) | (cfg_req_i.wdata & mask_wr_sel);
    s_d.report = evt_v;
    s_d.rsp.ack = cfg_req_i.valid;
    s_d.rsp.rdata = '0;
    if (cfg_req_i.valid && !cfg_req_i.write)
    begin
      if (hit_flags)
      begin
        s_d.rsp.rdata = s_q.flags & SBE_FLAGS_IMPL;
      end
      else if (hit_masks)
      begin
        s_d.rsp.rdata = s_q.masks & SBE_MASKS_IMPL;
      end
    end
  end

  always_ff @(posedge sys_clk_i or posedge bank_rst)
  begin
    if (bank_rst)
    begin
      s_q.flags <= SBE_FLAGS_RESET;
      s_q.masks <= SBE_MASKS_RESET;
      s_q.rsp <= '0;
      s_q.report <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign cfg_rsp_o = s_q.rsp;
  assign flags_o = s_q.flags;
  assign masks_o = s_q.masks;
  assign report_o = s_q.report;

  // ----------------------------------------------------------------
  // Assertion helpers
  // ----------------------------------------------------------------
  logic [SBE_REG_W-1:0] keep_v;
  logic [SBE_REG_W-1:0] blocked_v;
  logic [SBE_REG_W-1:0] setclr_v;
  logic [SBE_REG_W-1:0] mask_exp_v;

  assign keep_v = s_q.flags & ~clr_v;
  assign blocked_v = raw_v & s_q.masks & ~s_q.flags;
  assign setclr_v = evt_v & clr_v;
  assign mask_exp_v = (s_q.masks & ~mask_wr_sel) | (cfg_req_i.wdata & mask_wr_sel);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_flag_sticky;
    @(posedge sys_clk_i) disable iff (bank_rst)
    (|keep_v) |=> ((s_q.flags & $past(keep_v)) == $past(keep_v));
  endproperty
  a_flag_sticky: assert property (p_flag_sticky)
    else $error("set flag dropped without a write-one clear");

  property p_clear_by_one;
    @(posedge sys_clk_i) disable iff (bank_rst)
    (|(clr_v & ~evt_v)) |=> ((s_q.flags & $past(clr_v) & ~$past(evt_v)) == '0);
  endproperty
  a_clear_by_one: assert property (p_clear_by_one)
    else $error("write-one did not clear the flag");

  property p_syserr_sets;
    @(posedge sys_clk_i) disable iff (bank_rst)
    (sec_evt_i.system_error_seen && !s_q.masks[SBE_SYSERR_BIT])
      |=> (s_q.flags[SBE_SYSERR_BIT] && s_q.report[SBE_SYSERR_BIT]);
  endproperty
  a_syserr_sets: assert property (p_syserr_sets)
    else $error("system error not captured in bit 12");

  property p_parsig_sets;
    @(posedge sys_clk_i) disable iff (bank_rst)
    (sec_evt_i.parity_signal_seen && !s_q.masks[SBE_PARSIG_BIT])
      |=> s_q.flags[SBE_PARSIG_BIT];
  endproperty
  a_parsig_sets: assert property (p_parsig_sets)
    else $error("parity signal not captured in bit 11");

  property p_discard_sets;
    @(posedge sys_clk_i) disable iff (bank_rst)
    (sec_evt_i.discard_timer_expired && !s_q.masks[SBE_DISCARD_BIT])
      |=> s_q.flags[SBE_DISCARD_BIT];
  endproperty
  a_discard_sets: assert property (p_discard_sets)
    else $error("discard expiry not captured in bit 10");

  property p_addrpar_sets;
    @(posedge sys_clk_i) disable iff (bank_rst)
    (sec_evt_i.address_parity && !s_q.masks[SBE_ADDRPAR_BIT])
      |=> s_q.flags[SBE_ADDRPAR_BIT];
  endproperty
  a_addrpar_sets: assert property (p_addrpar_sets)
    else $error("address parity not captured in bit 9");

  property p_datapar_sets;
    @(posedge sys_clk_i) disable iff (bank_rst)
    ((sec_evt_i.write_data_parity || sec_evt_i.read_cpl_parity_signal)
      && !s_q.masks[SBE_DATAPAR_BIT]) |=> s_q.flags[SBE_DATAPAR_BIT];
  endproperty
  a_datapar_sets: assert property (p_datapar_sets)
    else $error("data parity not captured in bit 7");

  property p_mabort_sets;
    @(posedge sys_clk_i) disable iff (bank_rst)
    (sec_evt_i.master_abort && !s_q.masks[SBE_MABORT_BIT]) |=> s_q.flags[SBE_MABORT_BIT];
  endproperty
  a_mabort_sets: assert property (p_mabort_sets)
    else $error("master abort not captured in bit 3");

  property p_tabort_sets;
    @(posedge sys_clk_i) disable iff (bank_rst)
    (sec_evt_i.target_abort && !s_q.masks[SBE_TABORT_BIT]) |=> s_q.flags[SBE_TABORT_BIT];
  endproperty
  a_tabort_sets: assert property (p_tabort_sets)
    else $error("target abort not captured in bit 2");

  property p_reserved_zero;
    @(posedge sys_clk_i) disable iff (bank_rst)
    cfg_rsp_o.ack |-> (((s_q.flags & ~SBE_FLAGS_IMPL) == '0)
      && ((s_q.masks & ~SBE_MASKS_IMPL) == '0));
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved bit holds a one");

  property p_gated_blocked;
    @(posedge sys_clk_i) disable iff (bank_rst)
    (|blocked_v) |=> (((s_q.flags | s_q.report) & $past(blocked_v)) == '0);
  endproperty
  a_gated_blocked: assert property (p_gated_blocked)
    else $error("gated error reached flag or report");

  property p_mask_write;
    @(posedge sys_clk_i) disable iff (bank_rst)
    wr_masks |=> (s_q.masks == $past(mask_exp_v));
  endproperty
  a_mask_write: assert property (p_mask_write)
    else $error("gate register write not stored");

  property p_unused_gates_inert;
    @(posedge sys_clk_i) disable iff (bank_rst)
    (s_q.report & ~SBE_FLAGS_IMPL) == '0;
  endproperty
  a_unused_gates_inert: assert property (p_unused_gates_inert)
    else $error("report outside the implemented error bits");

  property p_reset_defaults;
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    !fundamental_reset_n |-> ((s_q.flags == SBE_FLAGS_RESET) && (s_q.masks == SBE_MASKS_RESET));
  endproperty
  a_reset_defaults: assert property (p_reset_defaults)
    else $error("registers not at defaults in fundamental reset");

  property p_set_wins;
    @(posedge sys_clk_i) disable iff (bank_rst)
    (|setclr_v) |=> ((s_q.flags & $past(setclr_v)) == $past(setclr_v));
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("clear beat a simultaneous error");

  property p_read_latency;
    @(posedge sys_clk_i) disable iff (bank_rst)
    (cfg_req_i.valid && !cfg_req_i.write && hit_flags)
      |=> (cfg_rsp_o.ack && (cfg_rsp_o.rdata == $past(s_q.flags)));
  endproperty
  a_read_latency: assert property (p_read_latency)
    else $error("flag read answer wrong or late");

  property p_ack_follows;
    @(posedge sys_clk_i) disable iff (bank_rst)
    cfg_req_i.valid |=> cfg_rsp_o.ack;
  endproperty
  a_ack_follows: assert property (p_ack_follows)
    else $error("configuration request not acknowledged");

  property p_unmapped_read_zero;
    @(posedge sys_clk_i) disable iff (bank_rst)
    (cfg_req_i.valid && !cfg_req_i.write && !hit_flags && !hit_masks)
      |=> (cfg_rsp_o.rdata == '0);
  endproperty
  a_unmapped_read_zero: assert property (p_unmapped_read_zero)
    else $error("unmapped read returned nonzero data");

  // ----------------------------------------------------------------
  // Coverage
  // ----------------------------------------------------------------
  c_clear: cover property (@(posedge sys_clk_i) disable iff (bank_rst) |(clr_v & s_q.flags));
  c_blocked: cover property (@(posedge sys_clk_i) disable iff (bank_rst) |blocked_v);
  c_set_clear: cover property (@(posedge sys_clk_i) disable iff (bank_rst) |setclr_v);
  c_unmask: cover property (@(posedge sys_clk_i) disable iff (bank_rst)
    wr_masks ##1 (|s_q.report));

endmodule : sbe_error_bank

// File: dv/sbe_sec_bus_model.sv
// Behavioural source of secondary-bus error events for the flag bank.
// Assumes the bench calls fire just after a rising clock edge.
`timescale 1ns/1ps
module sbe_sec_bus_model
  import sbe_pkg::*;
(
  // Clock
  input  wire logic sys_clk_i,
  // Events towards the bank
  output sbe_pkg::sbe_sec_evt_s evt_o
);
  initial evt_o = '0;

  // One-cycle pulse, then one quiet cycle so back-to-back calls never collide
  task automatic fire(input sbe_pkg::sbe_sec_evt_s e);
    evt_o = e;
    @(posedge sys_clk_i);
    #1;
    evt_o = '0;
    @(posedge sys_clk_i);
    #1;
  endtask : fire
endmodule : sbe_sec_bus_model

// File: dv/testbench.sv
// Self-checking bench for the secondary error flag and gate bank.
// Assumes the design files and the event model are compiled first.
`timescale 1ns/1ps
module testbench;
  import sbe_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic sys_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic pcie_n = 1'b1;
  logic global_rst_n = 1'b1;
  sbe_sec_evt_s evt;
  sbe_cfg_req_s req = '0;
  sbe_cfg_rsp_s rsp;
  logic fund_rst_n;
  logic [31:0] flags, masks, report, exp_f, exp_m, exp_r, raw, bm, clr;
  int err_total = 0;
  int compares = 0;
  localparam int pos[8] = '{2, 3, 7, 7, 9, 10, 11, 12};
  wire rst_any = sys_rst_i | !pcie_n | !global_rst_n;

  initial
  begin
    forever #5 sys_clk_i = ~sys_clk_i;
  end

  sbe_error_bank #(.REG_W(32)) uut (
    .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .pcie_reset_n_i(pcie_n),
    .global_reset_pin_n_i(global_rst_n), .sec_evt_i(evt), .cfg_req_i(req), .cfg_rsp_o(rsp),
    .fundamental_reset_n_o(fund_rst_n), .flags_o(flags), .masks_o(masks), .report_o(report)
  );
  sbe_sec_bus_model bus (.sys_clk_i(sys_clk_i), .evt_o(evt));

  // ----------------------------------------------------------------
  // Reference model
  // ----------------------------------------------------------------
  function automatic logic [31:0] evt_bits(input sbe_sec_evt_s e);
    evt_bits = '0;
    evt_bits[12] = e.system_error_seen;
    evt_bits[11] = e.parity_signal_seen;
    evt_bits[10] = e.discard_timer_expired;
    evt_bits[9] = e.address_parity;
    evt_bits[7] = e.write_data_parity | e.read_cpl_parity_signal;
    evt_bits[3] = e.master_abort;
    evt_bits[2] = e.target_abort;
  endfunction : evt_bits

  always @(posedge sys_clk_i or posedge rst_any)
  begin
    if (rst_any)
    begin
      exp_f <= 32'h0000_0000;
      exp_m <= 32'h0000_17A8;
      exp_r <= 32'h0000_0000;
    end
    else
    begin
      raw = evt_bits(evt) & ~exp_m;
      for (int i = 0; i < 4; i++) bm[8*i+:8] = {8{req.be[i]}};
      clr = (req.valid && req.write && req.addr == 12'h12C) ? (req.wdata & bm) : '0;
      exp_f <= ((exp_f & ~clr) | raw) & 32'h0000_1E8C;
      exp_r <= raw;
      if (req.valid && req.write && req.addr == 12'h130)
        exp_m <= ((exp_m & ~bm) | (req.wdata & bm)) & 32'h0000_3FEE;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  task automatic check_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check_word

  task automatic check_bit(input string what, input logic exp, input logic got);
    compares++;
    if (got !== exp)
    begin
      err_total++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
    end
  endtask : check_bit

  always @(negedge sys_clk_i)
  begin
    check_bit("fundamental_reset_n_o", pcie_n & global_rst_n, fund_rst_n);
    if (!rst_any)
    begin
      check_word("flags_o", exp_f, flags);
      check_word("masks_o", exp_m, masks);
      check_word("report_o", exp_r, report);
    end
  end

  // One configuration access; ack just after the taking edge, gone a cycle later
  task automatic cfg(input logic wr, input logic [11:0] a, input logic [3:0] be,
                     input logic [31:0] wd);
    logic [31:0] exp_rd;
    exp_rd = (a == 12'h12C) ? exp_f : ((a == 12'h130) ? exp_m : 32'h0000_0000);
    req = '{valid: 1'b1, write: wr, addr: a, be: be, wdata: wd};
    @(posedge sys_clk_i);
    #1;
    req.valid = 1'b0;
    check_bit("ack", 1'b1, rsp.ack);
    if (!wr)
      check_word("rdata", exp_rd, rsp.rdata);
    @(posedge sys_clk_i);
    #1;
    check_bit("ack_drop", 1'b0, rsp.ack);
  endtask : cfg

  task automatic end_of_test;
    $display("Comparisons %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_of_test

  // ----------------------------------------------------------------
  // Stimulus
  // ----------------------------------------------------------------
  initial
  begin
    logic [11:0] ra;
    void'($urandom(87866));
    repeat (10) @(posedge sys_clk_i);
    #1;
    sys_rst_i = 1'b0;
    cfg(1'b0, 12'h12C, 4'hF, 32'h0);
    cfg(1'b0, 12'h130, 4'hF, 32'h0);
    cfg(1'b1, 12'h130, 4'hF, 32'hFFFF_FFFF);
    cfg(1'b0, 12'h130, 4'hF, 32'h0);
    cfg(1'b1, 12'h130, 4'h2, 32'h0);
    cfg(1'b1, 12'h130, 4'hF, 32'h0);
    for (int i = 0; i < 8; i++)
    begin
      bus.fire(sbe_sec_evt_s'(8'(1 << i)));
      check_word("flag_pos", 32'h1 << pos[i], flags);
      cfg(1'b0, 12'h12C, 4'hF, 32'h0);
      cfg(1'b1, 12'h12C, 4'hF, 32'h0);
      fork
        bus.fire(sbe_sec_evt_s'(8'(1 << i)));
        cfg(1'b1, 12'h12C, 4'hF, 32'hFFFF_FFFF);
      join
      cfg(1'b1, 12'h12C, 4'hF, 32'hFFFF_FFFF);
    end
    cfg(1'b1, 12'h130, 4'hF, 32'h0000_3FEE);
    bus.fire(sbe_sec_evt_s'(8'hFF));
    cfg(1'b1, 12'h134, 4'hF, 32'hFFFF_FFFF);
    cfg(1'b0, 12'h134, 4'hF, 32'h0);
    repeat (300)
    begin
      ra = ($urandom % 2 != 0) ? 12'h12C : 12'h130;
      if ($urandom % 8 == 0)
        ra = 12'($urandom);
      fork
        bus.fire(sbe_sec_evt_s'(8'($urandom)));
        cfg(1'($urandom), ra, 4'($urandom), $urandom);
      join
    end
    for (int j = 0; j < 2; j++)
    begin
      cfg(1'b1, 12'h130, 4'hF, 32'h0);
      bus.fire(sbe_sec_evt_s'(8'hFF));
      if (j == 0)
        pcie_n = 1'b0;
      else
        global_rst_n = 1'b0;
      @(posedge sys_clk_i);
      #1;
      pcie_n = 1'b1;
      global_rst_n = 1'b1;
      cfg(1'b0, 12'h12C, 4'hF, 32'h0);
      cfg(1'b0, 12'h130, 4'hF, 32'h0);
    end
    end_of_test();
  end

  initial
  begin
    #100_000;
    err_total++;
    end_of_test();
  end
endmodule : testbench
